//--- iam_pkg.sv
// Constants, field layouts, control-ROM decodes and the state record
// of the address modification stages.
// Assumes one system clock and a 32-bit APB register port.
package iam_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IAM_VEC_OP_LENGTH_IDX = 10'h028;
  localparam logic [9:0] IAM_VEC_START_A_IDX   = 10'h029;
  localparam logic [9:0] IAM_VEC_START_B_IDX   = 10'h02a;
  localparam logic [9:0] IAM_VEC_START_C_IDX   = 10'h02b;
  localparam logic [9:0] IAM_INNER_AB_IDX      = 10'h02c;
  localparam logic [9:0] IAM_INNER_C_IDX       = 10'h02d;
  localparam logic [9:0] IAM_OUTER_AB_IDX      = 10'h02e;
  localparam logic [9:0] IAM_OUTER_C_IDX       = 10'h02f;
  localparam logic [9:0] IAM_CTRL_IDX          = 10'h030;
  localparam logic [9:0] IAM_STATUS_IDX        = 10'h031;
  localparam logic       IAM_ENABLE_RESET      = 1'b1;
  localparam logic [31:0] IAM_VEC_RESET        = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Instruction word fields (bit 0 of the word is the vector LSB)
  // ---------------------------------------------------------------
  localparam int IAM_OP_LSB = 24;
  localparam int IAM_R_LSB  = 20;
  localparam int IAM_T_LSB  = 16;
  localparam int IAM_M_LSB  = 12;
  localparam logic [23:0] IAM_OCTET_STEP = 24'h00_0008;

  // ---------------------------------------------------------------
  // Control ROM bit positions
  // ---------------------------------------------------------------
  localparam int IAM_RA_IDX_SHL   = 0;
  localparam int IAM_RA_IDX_SHR   = 1;
  localparam int IAM_RA_DISP_WIDE = 2;
  localparam int IAM_RA_BASE_PADR = 3;
  localparam int IAM_RB_BIE       = 0;
  localparam int IAM_RB_BRANCH    = 1;
  localparam int IAM_RB_MULTI     = 2;
  localparam int IAM_RB_DIRECT    = 3;
  localparam int IAM_RB_STORE     = 4;

  // Outcome of the branch, indirect and execute target search
  typedef enum logic [2:0] {
    IAM_BIE_NONE, IAM_BIE_HIT_STAGE_A, IAM_BIE_HIT_LEVEL1,
    IAM_BIE_HIT_PRESENT, IAM_BIE_HIT_LOOKAHEAD, IAM_BIE_MISS
  } iam_bie_t;

  // First-stage control ROM
  function automatic logic [31:0] iam_rom_a(input logic [7:0] op);
    logic [31:0] r;
    r = 32'h0;
    r[IAM_RA_IDX_SHL]   = (op[1:0] == 2'h2);
    r[IAM_RA_IDX_SHR]   = (op[1:0] == 2'h1);
    r[IAM_RA_DISP_WIDE] = op[2];
    r[IAM_RA_BASE_PADR] = (op[7:6] == 2'h2) && op[3];
    r[15:8]             = op;
    return r;
  endfunction : iam_rom_a

  // Second-stage control ROM
  function automatic logic [31:0] iam_rom_b(input logic [7:0] op);
    logic [31:0] r;
    r = 32'h0;
    r[IAM_RB_BIE]    = op[7];
    r[IAM_RB_BRANCH] = (op[7:6] == 2'h2);
    r[IAM_RB_MULTI]  = (op[7:6] == 2'h0) && (op[5:4] == 2'h3);
    r[IAM_RB_DIRECT] = (op[7:6] == 2'h1) && op[5];
    r[IAM_RB_STORE]  = (op[7:6] == 2'h0) && op[4];
    return r;
  endfunction : iam_rom_b

  // Whole state of the block
  typedef struct packed {
    logic             a_active;
    logic [31:0]      a_instr;
    logic [23:0]      a_addr;
    logic [31:0]      a_ctrl;
    logic [31:0]      a_index;
    logic [31:0]      a_base;
    logic [3:0]       a_rfield;
    logic             b_active;
    logic [7:0]       b_op;
    logic [23:0]      b_ar;
    logic [23:0]      b_addr;
    logic [23:0]      b_supp;
    logic [3:0]       b_rfield;
    logic [3:0]       b_beats;
    logic             out_valid;
    logic             out_store;
    logic [63:0]      ao;
    logic [31:0]      ro;
    logic [3:0]       out_rfield;
    logic [23:0]      out_ctrl;
    logic             fl_valid;
    logic [23:0]      fl_addr;
    logic [23:0]      oa;
    logic             bie_valid;
    iam_bie_t         bie;
    logic [23:0]      bie_addr;
    logic             restart;
    logic             enable;
    logic [7:0][31:0] vfile;
    logic [31:0]      prdata;
    logic             pslverr;
  } iam_state_t;

endpackage : iam_pkg

//--- iam_top.sv
// Address modification stages: operand select, displacement and index
// shaping, effective address adder, hazard restart and target search.
// Assumes register file read ports, hazard flags and fetch addresses
// come from neighbouring logic, all synchronous to pclk.
//
// How it works
// - Opcode decoded by control ROM into 32 bits on entry to stage A.
// - Result field held in stage A, passed on, exposed for hazards.
// - Nonzero index field picks one of seven index words into holder.
// - Index shifted left, right or passed unchanged per ROM bits.
// - Displacement is 12 or 16 low bits sign-extended to 24.
// - Stage A instruction address held, exported to comparators.
// - Nonzero base field reads a base word into the base holder.
// - ROM bit selects base holder or stage A address as base term.
// - Stage A advances only with no far hazard and stage B free.
// - Base, displacement and index summed in 24 bits into result.
// - Multiple load or store steps result by one octet per beat.
// - Branch may load fetch address from result; indirect, execute do not.
// - Operand address or immediate moves to address output register.
// - Stage B address loads from stage A; may go out as operand.
// - Second ROM decodes opcode; branch type starts target search.
// - 24 ROM bits captured in supplement register on advance.
// - Stage B result field selects operand word, forwarded out.
// - Hazard in stage B refetches it and flushes younger stages.
// - Output transfer happens only when downstream is ready.
// - Target compared with stage A then level-1 address first.
// - Then octet compared with present and look-ahead fetch octets.
// - All miss: result to operand fetch address, fetch from memory.
// - Index field zero gives a zero index term.
// - Base field zero reads no base register.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module iam_top
  import iam_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        l1_valid,
  input  wire logic [31:0] l1_instr,
  input  wire logic [23:0] level1_instr_addr,
  output logic             l1_accept,
  input  wire logic        far_hazard,
  output logic [2:0]       rf_index_sel,
  input  wire logic [31:0] rf_index_data,
  output logic [3:0]       rf_base_sel,
  output logic             rf_base_rd,
  input  wire logic [31:0] rf_base_data,
  output logic [3:0]       rf_result_sel,
  input  wire logic [31:0] rf_result_data,
  input  wire logic        stage_b_hazard,
  input  wire logic        out_ready,
  output logic             out_valid,
  output logic             out_store,
  output logic [63:0]      address_output_reg,
  output logic [31:0]      operand_output_reg,
  output logic [3:0]       out_result_field,
  output logic [23:0]      out_ctrl,
  input  wire logic [23:0] present_fetch_addr,
  input  wire logic [23:0] lookahead_fetch_addr,
  output logic             fetch_load,
  output logic [23:0]      fetch_load_addr,
  output logic [23:0]      operand_fetch_addr,
  output logic             bie_valid,
  output iam_bie_t         bie_outcome,
  output logic [23:0]      bie_target,
  output logic             restart,
  output logic [3:0]       stage_a_result_field,
  output logic [3:0]       stage_b_result_field,
  output logic [23:0]      stage_a_instr_addr,
  output logic [23:0]      stage_b_instr_addr,
  output logic [23:0]      adder_result_reg,
  output logic [23:0]      supplement_control_reg,
  output logic             stage_a_active,
  output logic             stage_b_active
);

  // ---------------------------------------------------------------
  // Decode and datapath
  // ---------------------------------------------------------------
  iam_state_t  s_reg;
  iam_state_t  s_next;
  logic [31:0] rb;
  logic [23:0] idx_term;
  logic [23:0] disp_term;
  logic [23:0] base_term;
  logic [23:0] sum;
  logic [31:0] shifted;
  logic [2:0]  t_in;
  logic [3:0]  m_in;
  logic        flush;
  logic        b_bie_go;
  logic        b_xfer;
  logic        b_more;
  logic        b_can_accept;
  logic        a_adv;
  logic        a_take;
  logic [9:0]  idx;
  logic        in_vfile;
  logic        hit;
  logic        apb_wr;
  logic [31:0] rd_word;

  assign rb = iam_rom_b(s_reg.b_op);
  assign t_in = l1_instr[IAM_T_LSB +: 3];
  assign m_in = l1_instr[IAM_M_LSB +: 4];

  // Register file selects for the word entering stage A and the stage B operand word
  // index word select
  assign rf_index_sel = t_in;
  // no base read on zero field
  assign rf_base_sel = m_in;
  assign rf_base_rd  = (m_in != 4'h0);
  // result field picks the operand word
  assign rf_result_sel = s_reg.b_rfield;

  // Index shaper: the shift is done on the full word so that no
  // upper index bit is lost for a right shift
  // index shift network
  always_comb
  begin
    if (s_reg.a_ctrl[IAM_RA_IDX_SHL])
      shifted = s_reg.a_index << 1;
    else if (s_reg.a_ctrl[IAM_RA_IDX_SHR])
      shifted = s_reg.a_index >> 1;
    else
      shifted = s_reg.a_index;
  end
  assign idx_term = shifted[23:0];

  assign disp_term = s_reg.a_ctrl[IAM_RA_DISP_WIDE]
                   ? {{8{s_reg.a_instr[15]}}, s_reg.a_instr[15:0]}
                   : {{12{s_reg.a_instr[11]}}, s_reg.a_instr[11:0]};
  assign base_term = s_reg.a_ctrl[IAM_RA_BASE_PADR] ? s_reg.a_addr : s_reg.a_base[23:0];
  assign sum = base_term + disp_term + idx_term;

  // ---------------------------------------------------------------
  // Stage handshakes
  // ---------------------------------------------------------------
  // hazard in stage B wins over every other pipeline action; APB reads and writes still proceed
  assign flush    = s_reg.b_active && stage_b_hazard;
  // second ROM starts the target search
  assign b_bie_go = s_reg.b_active && !stage_b_hazard && rb[IAM_RB_BIE];
  assign b_xfer   = s_reg.b_active && !stage_b_hazard && !rb[IAM_RB_BIE] && out_ready;
  assign b_more   = rb[IAM_RB_MULTI] && (s_reg.b_beats != 4'h0);
  assign b_can_accept = !s_reg.b_active || (b_xfer && !b_more) || b_bie_go;
  // advance only with no far hazard and stage B free
  assign a_adv    = s_reg.a_active && !far_hazard && b_can_accept && !flush;
  assign a_take   = s_reg.enable && l1_valid && (!s_reg.a_active || a_adv) && !flush;
  assign l1_accept = a_take;

  // ---------------------------------------------------------------
  // APB decode; zero wait states, so pready is always high
  // ---------------------------------------------------------------
  assign idx      = paddr[11:2];
  assign in_vfile = (idx >= IAM_VEC_OP_LENGTH_IDX) && (idx <= IAM_OUTER_C_IDX);
  assign hit      = in_vfile || (idx == IAM_CTRL_IDX) || (idx == IAM_STATUS_IDX);
  assign apb_wr   = psel && penable && pwrite && hit;
  assign pready   = 1'b1;

  always_comb
  begin
    if (in_vfile)
      rd_word = s_reg.vfile[idx[2:0]];
    else if (idx == IAM_CTRL_IDX)
      rd_word = {31'h0, s_reg.enable};
    else if (idx == IAM_STATUS_IDX)
      rd_word = {27'h0, s_reg.bie, s_reg.b_active, s_reg.a_active};
    else
      rd_word = 32'h0;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next           = s_reg; // stalled stages hold
    s_next.out_valid = 1'b0;
    s_next.fl_valid  = 1'b0;
    s_next.bie_valid = 1'b0;
    s_next.restart   = 1'b0;
    // Read data is caught in the setup phase and stands in the access phase
    if (psel && !penable)
    begin
      s_next.prdata  = rd_word;
      s_next.pslverr = !hit;
    end
    if (apb_wr && in_vfile)
      s_next.vfile[idx[2:0]] = pwdata;
    if (apb_wr && (idx == IAM_CTRL_IDX))
      s_next.enable = pwdata[0];
    if (flush)
    begin
      // refetch the stage B instruction, drop younger ones
      s_next.a_active = 1'b0;
      s_next.b_active = 1'b0;
      s_next.fl_valid = 1'b1;
      s_next.fl_addr  = s_reg.b_addr;
      s_next.restart  = 1'b1;
    end
    else
    begin
      if (b_xfer)
      begin
        // address or immediate to the output level
        s_next.out_valid  = 1'b1;
        s_next.out_store  = rb[IAM_RB_STORE];
        // instruction address sent as a direct operand
        s_next.ao = rb[IAM_RB_DIRECT] ? {{40{s_reg.b_addr[23]}}, s_reg.b_addr}
                                      : {{40{s_reg.b_ar[23]}}, s_reg.b_ar};
        s_next.ro         = rf_result_data;
        // field forwarded to the register stack
        s_next.out_rfield = s_reg.b_rfield;
        s_next.out_ctrl   = s_reg.b_supp;
        if (b_more)
        begin
          // next octet address from the feedback path
          s_next.b_ar    = s_reg.b_ar + IAM_OCTET_STEP;
          s_next.b_beats = s_reg.b_beats - 4'h1;
        end
        else
          s_next.b_active = 1'b0;
      end
      if (b_bie_go)
      begin
        s_next.bie_valid = 1'b1;
        s_next.bie_addr  = s_reg.b_ar;
        s_next.b_active  = 1'b0;
        // stage A, then level 1, full address match
        if (s_reg.a_active && (s_reg.b_ar == s_reg.a_addr))
          s_next.bie = IAM_BIE_HIT_STAGE_A;
        else if (l1_valid && (s_reg.b_ar == level1_instr_addr))
          s_next.bie = IAM_BIE_HIT_LEVEL1;
        // octet compare against the fetch addresses
        else if (s_reg.b_ar[23:3] == present_fetch_addr[23:3])
          s_next.bie = IAM_BIE_HIT_PRESENT;
        else if (s_reg.b_ar[23:3] == lookahead_fetch_addr[23:3])
          s_next.bie = IAM_BIE_HIT_LOOKAHEAD;
        else
        begin
          s_next.bie = IAM_BIE_MISS;
          s_next.oa  = s_reg.b_ar;
        end
        // a branch outside the pipeline reloads fetch
        if (rb[IAM_RB_BRANCH] && (s_next.bie != IAM_BIE_HIT_STAGE_A)
            && (s_next.bie != IAM_BIE_HIT_LEVEL1))
        begin
          s_next.fl_valid = 1'b1;
          s_next.fl_addr  = s_reg.b_ar;
        end
      end
      if (a_adv)
      begin
        // result loaded when stage A hands over
        s_next.b_active = 1'b1;
        s_next.b_ar     = sum;
        s_next.b_op     = s_reg.a_instr[IAM_OP_LSB +: 8];
        // stage B address from stage A
        s_next.b_addr   = s_reg.a_addr;
        s_next.b_supp   = s_reg.a_ctrl[23:0];
        s_next.b_rfield = s_reg.a_rfield;
        s_next.b_beats  = s_reg.a_rfield;
        s_next.a_active = 1'b0;
      end
      if (a_take)
      begin
        s_next.a_active = 1'b1;
        s_next.a_instr  = l1_instr;
        s_next.a_addr   = level1_instr_addr;
        s_next.a_ctrl   = iam_rom_a(l1_instr[IAM_OP_LSB +: 8]);
        s_next.a_rfield = l1_instr[IAM_R_LSB +: 4];
        // zero index field gives zero term
        s_next.a_index  = (t_in != 3'h0) ? rf_index_data : 32'h0;
        // base word for a nonzero base field
        s_next.a_base   = (m_in != 4'h0) ? rf_base_data : 32'h0;
      end
    end
  end

  // State register; only constants under reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg        <= '0;
      s_reg.bie    <= IAM_BIE_NONE;
      s_reg.enable <= IAM_ENABLE_RESET;
      s_reg.vfile  <= {8{IAM_VEC_RESET}};
    end
    else
      s_reg <= s_next;
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops except the handshakes, pslverr, rf_index_sel, rf_base_sel and rf_base_rd
  // ---------------------------------------------------------------
  assign prdata                 = s_reg.prdata;
  assign pslverr                = s_reg.pslverr && psel && penable;
  assign out_valid              = s_reg.out_valid;
  assign out_store              = s_reg.out_store;
  assign address_output_reg     = s_reg.ao;
  assign operand_output_reg     = s_reg.ro;
  assign out_result_field       = s_reg.out_rfield;
  assign out_ctrl               = s_reg.out_ctrl;
  assign fetch_load             = s_reg.fl_valid;
  assign fetch_load_addr        = s_reg.fl_addr;
  assign operand_fetch_addr     = s_reg.oa;
  assign bie_valid              = s_reg.bie_valid;
  assign bie_outcome            = s_reg.bie;
  assign bie_target             = s_reg.bie_addr;
  assign restart                = s_reg.restart;
  assign stage_a_result_field   = s_reg.a_rfield;
  assign stage_b_result_field   = s_reg.b_rfield;
  assign stage_a_instr_addr     = s_reg.a_addr;
  assign stage_b_instr_addr     = s_reg.b_addr;
  assign adder_result_reg       = s_reg.b_ar;
  assign supplement_control_reg = s_reg.b_supp;
  assign stage_a_active         = s_reg.a_active;
  assign stage_b_active         = s_reg.b_active;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rom_on_entry_a: assert property (a_take |=> s_reg.a_ctrl == iam_rom_a($past(l1_instr[31:24])))
    else $error("stage A control word does not match ROM");
  zero_index_a: assert property (a_take && (t_in == 3'h0) |=> s_reg.a_index == 32'h0)
    else $error("zero index field gave nonzero index word");
  far_hazard_a: assert property (s_reg.a_active && far_hazard && !flush |=> s_reg.a_active && $stable(s_reg.a_addr))
    else $error("stage A moved under far hazard");
  handover_a: assert property (a_adv |=> s_reg.b_addr == $past(s_reg.a_addr) && s_reg.b_supp == $past(s_reg.a_ctrl[23:0]))
    else $error("stage B address or supplement not loaded");
  stall_hold_a: assert property (s_reg.b_active && !stage_b_hazard && !rb[IAM_RB_BIE] && !out_ready |=> s_reg.b_active && $stable(s_reg.b_ar) && $stable(s_reg.b_addr))
    else $error("stalled stage B changed");
  out_gate_a: assert property (s_reg.out_valid |-> $past(out_ready) && !$past(stage_b_hazard))
    else $error("output level loaded without ready");
  restart_addr_a: assert property (flush |=> s_reg.fl_valid && s_reg.restart && s_reg.fl_addr == $past(s_reg.b_addr) ##1 !s_reg.fl_valid)
    else $error("hazard restart not issued");
  octet_step_a: assert property (b_xfer && b_more && !flush |=> s_reg.b_ar == $past(s_reg.b_ar) + IAM_OCTET_STEP)
    else $error("multiple transfer did not step one octet");
  miss_oa_a: assert property (s_reg.bie_valid && s_reg.bie == IAM_BIE_MISS |-> s_reg.oa == s_reg.bie_addr)
    else $error("miss did not copy target to operand fetch address");
  apb_error_a: assert property (psel && !penable && !hit |=> pslverr)
    else $error("unmapped access did not report an error");

  restart_seen_c: cover property (flush ##1 s_reg.restart);
  hit_stage_a_c:  cover property (s_reg.bie_valid && s_reg.bie == IAM_BIE_HIT_STAGE_A);
  multi_run_c:    cover property (b_xfer && b_more ##1 b_xfer && b_more);
  out_xfer_c:     cover property (a_take ##[1:4] s_reg.out_valid);

endmodule : iam_top

`default_nettype wire

//--- iam_far_model.sv
// Far side model: register file reads, fetch octets, output level.
// Assumes the bench raises hold_off to stall the output level.
`timescale 1ns/1ns
`default_nettype none
module iam_far_model
(
  input  wire logic        pclk,
  input  wire logic        hold_off,
  input  wire logic [2:0]  rf_index_sel,
  input  wire logic [3:0]  rf_base_sel,
  input  wire logic        rf_base_rd,
  input  wire logic [3:0]  rf_result_sel,
  output logic [31:0]      rf_index_data,
  output logic [31:0]      rf_base_data,
  output logic [31:0]      rf_result_data,
  output logic             out_ready,
  output logic [23:0]      present_fetch_addr,
  output logic [23:0]      lookahead_fetch_addr
);
  logic [31:0] junk_reg = 32'h5a3c_0f96;
  // Unread ports churn so a stray use spoils the sum
  always_ff @(posedge pclk)
    junk_reg <= ~junk_reg + 32'h0000_0135;
  assign rf_index_data  = (rf_index_sel != 3'h0) ? {29'h0, rf_index_sel} + 32'h100 : junk_reg;
  assign rf_base_data   = rf_base_rd ? {28'h0, rf_base_sel} + 32'h1000 : junk_reg;
  assign rf_result_data = {28'h0, rf_result_sel} + 32'h2000;
  // Octets apart so each target meets one compare only
  assign present_fetch_addr   = 24'h00_5000;
  assign lookahead_fetch_addr = 24'h00_5008;
  assign out_ready            = ~hold_off;
endmodule : iam_far_model
`default_nettype wire

//--- tb_top.sv
// Bench for the address stages: APB, pipeline, hazards, target search.
// Assumes iam_pkg and the far side model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("BAD %0t %h %h", $time, a, e); end end
module tb_top
  import iam_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, l1_valid, l1_accept;
  logic        far_hazard, rf_base_rd, stage_b_hazard, out_ready, out_valid, fetch_load;
  logic        bie_valid, restart, stage_a_active, stage_b_active, hold_off, out_store;
  logic [2:0]  rf_index_sel;
  logic [3:0]  rf_base_sel, rf_result_sel, out_result_field, stage_a_result_field;
  logic [3:0]  stage_b_result_field;
  logic [11:0] paddr;
  logic [23:0] level1_instr_addr, present_fetch_addr, lookahead_fetch_addr, fetch_load_addr;
  logic [23:0] operand_fetch_addr, bie_target, stage_a_instr_addr, stage_b_instr_addr, out_ctrl;
  logic [31:0] pwdata, prdata, l1_instr, rf_index_data, rf_base_data, rf_result_data;
  logic [31:0] operand_output_reg;
  logic [63:0] address_output_reg;
  iam_bie_t    bie_outcome;
  int          failures, checks;

  iam_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .l1_valid, .l1_instr, .level1_instr_addr, .l1_accept, .far_hazard, .rf_index_sel,
    .rf_index_data, .rf_base_sel, .rf_base_rd, .rf_base_data, .rf_result_sel, .rf_result_data,
    .stage_b_hazard, .out_ready, .out_valid, .out_store, .address_output_reg,
    .operand_output_reg, .out_result_field, .out_ctrl, .present_fetch_addr,
    .lookahead_fetch_addr, .fetch_load, .fetch_load_addr, .operand_fetch_addr, .bie_valid,
    .bie_outcome, .bie_target, .restart, .stage_a_result_field, .stage_b_result_field,
    .stage_a_instr_addr, .stage_b_instr_addr, .adder_result_reg(), .supplement_control_reg(),
    .stage_a_active, .stage_b_active);
  iam_far_model far_u (.pclk, .hold_off, .rf_index_sel, .rf_base_sel, .rf_base_rd,
    .rf_result_sel, .rf_index_data, .rf_base_data, .rf_result_data, .out_ready,
    .present_fetch_addr, .lookahead_fetch_addr);

  // ----
  // Shared tasks
  // ----
  task automatic stop_test();
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Bounded wait at falling edges, where outputs are settled
  task automatic wait_hi(ref logic s);
    int n = 0;
    do @(negedge pclk); while (s !== 1'b1 && ++n < 80);
    if (n >= 80)
    begin
      failures++;
      stop_test();
    end
  endtask : wait_hi

  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 80);
    if (n >= 80)
    begin
      failures++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // Released source shows inverted junk, not the last word
  task automatic send(input logic [31:0] w, input logic [23:0] a);
    @(posedge pclk);
    {l1_valid, l1_instr, level1_instr_addr} <= {1'b1, w, a};
    wait_hi(l1_accept);
    @(posedge pclk);
    {l1_valid, l1_instr} <= {1'b0, ~w};
  endtask : send

  task automatic wait_out(input logic [23:0] ea, input logic [3:0] r);
    wait_hi(out_valid);
    `CHK(address_output_reg, {{40{ea[23]}}, ea})
    `CHK(out_result_field, r)
  endtask : wait_out

  // Effective address from the field layout and stage A ROM
  function automatic logic [23:0] exp_ea(input logic [31:0] w, input logic [23:0] a);
    logic [31:0] x = (w[18:16] != 3'h0) ? {29'h0, w[18:16]} + 32'h100 : 32'h0;
    logic [23:0] d = w[26] ? {{8{w[15]}}, w[15:0]} : {{12{w[11]}}, w[11:0]};
    logic [23:0] b = (w[15:12] != 4'h0) ? {20'h0, w[15:12]} + 24'h1000 : 24'h0;
    if (w[31:30] == 2'h2 && w[27])
      b = a;
    x = (w[25:24] == 2'h2) ? x << 1 : (w[25:24] == 2'h1) ? x >> 1 : x;
    return b + d + x[23:0];
  endfunction : exp_ea

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, IAM_VEC_START_A_IDX, 32'h0, q, e);
    `CHK(q, IAM_VEC_RESET) // reset value
    apb(1'b1, IAM_VEC_START_A_IDX, 32'h1234_5678, q, e);
    apb(1'b0, IAM_VEC_START_A_IDX, 32'h0, q, e);
    `CHK(q, 32'h1234_5678) // read back
    apb(1'b0, IAM_CTRL_IDX, 32'h0, q, e);
    `CHK(q[0], IAM_ENABLE_RESET) // enable at reset
    apb(1'b1, 10'h000, 32'h1, q, e);
    `CHK(e, 1'b1) // unmapped
  endtask : t_regs

  task automatic t_forms();
    logic [7:0]  ops [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
    logic [31:0] w;
    foreach (ops[i])
    begin
      w = {ops[i], 4'h5, 4'h3, 16'h2810};
      send(w, 24'h000100);
      wait_out(exp_ea(w, 24'h0), 4'h5);
      `CHK(operand_output_reg, 32'h2005)
      `CHK(out_ctrl[15:8], ops[i])
    end
  endtask : t_forms

  task automatic t_stall();
    @(posedge pclk);
    hold_off <= 1'b1;
    send({8'h00, 4'h6, 4'h0, 16'h0004}, 24'h000200);
    send({8'h00, 4'h7, 4'h1, 16'h1008}, 24'h000204);
    repeat (6) @(negedge pclk);
    `CHK({out_valid, stage_a_active, stage_b_active}, 3'b011)
    `CHK({stage_a_instr_addr, stage_b_instr_addr}, 48'h000204_000200)
    `CHK({stage_a_result_field, stage_b_result_field}, 8'h76)
    @(posedge pclk);
    hold_off <= 1'b0;
    wait_out(24'h000004, 4'h6);
    wait_out(24'h00110a, 4'h7);
  endtask : t_stall

  task automatic t_multi();
    send({8'h30, 4'h2, 4'h0, 16'h0040}, 24'h000300);
    for (int k = 0; k < 3; k++)
      wait_out(24'h40 + 24'(k) * IAM_OCTET_STEP, 4'h2);
    @(negedge pclk);
    `CHK({out_valid, stage_b_active, out_store}, 3'b001)
  endtask : t_multi

  task automatic t_hazard();
    @(posedge pclk);
    far_hazard <= 1'b1;
    send({8'h00, 4'h1, 4'h0, 16'h0123}, 24'h000400);
    repeat (4) @(negedge pclk);
    `CHK({stage_a_active, stage_b_active}, 2'b10)
    @(posedge pclk);
    {far_hazard, hold_off} <= 2'b00;
    wait_out(24'h000123, 4'h1);
    send({8'h00, 4'h3, 4'h0, 16'h0060}, 24'h000504);
    @(posedge pclk);
    stage_b_hazard <= 1'b1;
    wait_hi(restart);
    `CHK({fetch_load, fetch_load_addr}, {1'b1, 24'h000504})
    @(posedge pclk);
    {stage_b_hazard, hold_off} <= 2'b00;
    @(negedge pclk);
    `CHK({stage_a_active, stage_b_active, out_valid}, 3'b000)
  endtask : t_hazard

  task automatic t_bie();
    logic [7:0]  ops [4] = '{8'hc0, 8'h84, 8'h84, 8'h88};
    logic [15:0] lo [4] = '{16'h07f0, 16'h4003, 16'h400a, 16'h0010};
    iam_bie_t    res [4] = '{IAM_BIE_MISS, IAM_BIE_HIT_PRESENT, IAM_BIE_HIT_LOOKAHEAD, IAM_BIE_MISS};
    logic [23:0] t;
    foreach (ops[i])
    begin
      t = exp_ea({ops[i], 8'h0, lo[i]}, 24'h005000);
      send({ops[i], 8'h0, lo[i]}, 24'h005000);
      wait_hi(bie_valid);
      `CHK({bie_outcome, bie_target}, {res[i], t})
      if (ops[i][7:6] == 2'h2)
        `CHK({fetch_load, fetch_load_addr}, {1'b1, t})
      if (res[i] == IAM_BIE_MISS)
        `CHK(operand_fetch_addr, t)
    end
  endtask : t_bie

  // hits in stage A and level 1
  task automatic t_near();
    @(posedge pclk);
    {l1_valid, l1_instr} <= {1'b1, 32'hc000_0600};
    wait_hi(l1_accept);
    @(posedge pclk);
    {l1_instr, level1_instr_addr} <= {32'h0, 24'h000600};
    @(posedge pclk);
    l1_valid <= 1'b0;
    wait_hi(bie_valid);
    `CHK(bie_outcome, IAM_BIE_HIT_STAGE_A)
    send(32'hc000_0600, 24'h000010);
    send(32'h0, 24'h000600);
    wait_hi(bie_valid);
    `CHK(bie_outcome, IAM_BIE_HIT_LEVEL1)
  endtask : t_near

  initial
    forever #20 pclk = ~pclk;

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, l1_valid, far_hazard, stage_b_hazard} = '0;
    {hold_off, paddr, pwdata, l1_instr, level1_instr_addr, failures, checks} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_forms();
    t_stall();
    t_multi();
    t_hazard();
    t_bie();
    t_near();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
